// ===== pdis_ctrl_model.sv
// Behavioural system controller for the three-wire serial link.
// Assumes the device samples data on rising serial clock and that the
// caller leaves at least one microsecond between transfers.
`timescale 1ns/1ns
module pdis_ctrl_model
(
   output logic sclk,
   output logic ce,
   output logic sdi,
   input wire logic sdo
);
   // Half periods of a 125 ns serial clock, phase unrelated to clk_sys
   localparam int HALF_LO = 62;
   localparam int HALF_HI = 63;

   // Idle link: clock stands still low, enable low
   initial
   begin
      sclk = 1'b0;
      ce = 1'b0;
      sdi = 1'b0;
   end

   // One transfer, MSB first; output bits are taken just before the
   // next rising edge, so the device's flop has long settled
   task automatic xfer(input logic [31:0] word, input int nbits, output logic [15:0] rd);
      // Start off the system clock edge so the two clocks keep no phase tie
      #7;
      rd = 16'h0000;
      ce = 1'b1;
      for (int i = 0; i < nbits; i++)
      begin
         sdi = word[31-i];
         #HALF_LO;
         if (i >= 1 && i <= 16)
            rd[16-i] = sdo;
         sclk = 1'b1;
         #HALF_HI sclk = 1'b0;
      end
      #HALF_LO ce = 1'b0;
      // Released line shows no stale value
      sdi = ~sdi;
   endtask
endmodule

// ===== pdis_divider.sv
// Programmable divider with band and mode selection, in the system
// clock domain. Assumes both oscillator inputs are far below half the
// system clock, since they are sampled, not used as clocks.
`timescale 1ns/1ns
module pdis_divider
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic run,
   input wire logic restart,
   input wire pdis_pkg::pdis_cfg_t cfg,
   input wire logic high_band_lo_input,
   input wire logic low_band_lo_input,
   output logic pulse,
   output logic active
);

   typedef enum {DV_IDLE, DV_COUNT} pdis_dv_t;

   pdis_dv_t state_reg;
   pdis_dv_t state_next;
   logic [2:0] hb_sync_reg; // Two sync stages plus edge history
   logic [2:0] lb_sync_reg;
   logic pre_reg; // Divide-by-two prescaler
   logic [15:0] cnt_reg;
   logic pulse_reg;

   wire hb_edge = hb_sync_reg[1] & ~hb_sync_reg[2];
   wire lb_edge = lb_sync_reg[1] & ~lb_sync_reg[2];
   // High band counts every second edge low band every edge
   wire src_edge = cfg.band ? (hb_edge & pre_reg) : lb_edge;
   wire wide = cfg.band | cfg.swallow;
   // Direct mode uses only twelve bits
   wire [15:0] limit = wide ? cfg.divisor : {4'h0, cfg.divisor[11:0]};
   wire ok = pdis_pkg::pdis_cfg_ok(wide, cfg.divisor);
   wire wrap = (cnt_reg == limit - 16'h0001);

   // Synchronise the oscillator pins
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         hb_sync_reg <= 3'h0;
         lb_sync_reg <= 3'h0;
         pre_reg <= 1'b0;
      end
      else
      begin
         hb_sync_reg <= {hb_sync_reg[1:0], high_band_lo_input};
         lb_sync_reg <= {lb_sync_reg[1:0], low_band_lo_input};
         pre_reg <= hb_edge ? ~pre_reg : pre_reg;
      end
   end

   // Counting only with a valid setting
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         DV_IDLE: if (run && ok) state_next = DV_COUNT;
         DV_COUNT: if (!(run && ok)) state_next = DV_IDLE;
         default: state_next = DV_IDLE;
      endcase
   end

   // Counter wraps after exactly the programmed number of edges
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_reg <= DV_IDLE;
         cnt_reg <= 16'h0000;
         pulse_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         pulse_reg <= (state_reg == DV_COUNT) && src_edge && wrap && !restart;
         if (state_reg != DV_COUNT || restart)
            cnt_reg <= 16'h0000;
         else if (src_edge)
            cnt_reg <= wrap ? 16'h0000 : cnt_reg + 16'h0001;
      end
   end

   assign pulse = pulse_reg;
   assign active = (state_reg == DV_COUNT);

   a_prescale_skip: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (cfg.band && hb_edge && !pre_reg) |-> !src_edge)
      else $error("prescaler did not halve");
   a_low_source: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !cfg.band |-> (src_edge == lb_edge))
      else $error("wrong low band source");
   a_pulse_count: assert property (@(posedge clk_sys) disable iff (!reset_n)
      pulse_reg |-> ($past(cnt_reg) == $past(limit) - 16'h0001))
      else $error("pulse at wrong count");
   a_range_halt: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !ok |=> state_reg == DV_IDLE)
      else $error("divider ran out of range");
   c_high_pulse: cover property (@(posedge clk_sys) disable iff (!reset_n)
      cfg.band && pulse_reg);

endmodule

// ===== pdis_pkg.sv
// Shared constants, frame layout and carrier types for the divider
// input selector. Assumes a 32-bit classic Wishbone host and a serial
// controller that sends one fixed-length frame per transfer.
package pdis_pkg;

   // Serial frame length in link clock cycles
   localparam int FRAME_BITS = 32;

   // Field positions inside a received frame
   localparam int DIV_LSB = 0;
   localparam int BAND_BIT = 16;
   localparam int SWAL_BIT = 17;
   localparam int DOC_LSB = 18;
   localparam int BO_LSB = 21;
   localparam int IODIR_LSB = 26;
   localparam int IODAT_LSB = 28;
   localparam int CFG_W = 30;

   // Accepted divisor ranges
   localparam logic [15:0] SWAL_MIN = 16'h0110;
   localparam logic [15:0] SWAL_MAX = 16'hFFFF;
   localparam logic [15:0] DIR_MIN = 16'h0004;
   localparam logic [15:0] DIR_MAX = 16'h0FFF;

   // Output content codes for the serial output pin
   localparam logic [2:0] DOC_OPEN = 3'h0;
   localparam logic [2:0] DOC_IO = 3'h1;
   localparam logic [2:0] DOC_DIV = 3'h2;
   localparam logic [2:0] DOC_PULSE = 3'h3;

   // Register byte offsets
   localparam logic [4:0] ADR_CTRL = 5'h00;
   localparam logic [4:0] ADR_STATUS = 5'h04;
   localparam logic [4:0] ADR_DIVISOR = 5'h08;
   localparam logic [4:0] ADR_PULSES = 5'h0C;
   localparam logic [4:0] ADR_CONFIG = 5'h10;

   // Reset values
   localparam logic CTRL_RUN_RST = 1'b1;
   localparam logic [CFG_W-1:0] CFG_RST = 30'h00000000;

   // Control data held after a frame, high bits first in the frame
   typedef struct packed {
      logic [1:0] io_dat;
      logic [1:0] io_dir;
      logic [4:0] bo;
      logic [2:0] doc;
      logic swallow;
      logic band;
      logic [15:0] divisor;
   } pdis_cfg_t;

   // Divisor range check, shared by divider and status
   function automatic logic pdis_cfg_ok(input logic wide, input logic [15:0] div);
      if (wide)
         return (div >= SWAL_MIN) && (div <= SWAL_MAX);
      return (div >= DIR_MIN) && (div <= DIR_MAX);
   endfunction

endpackage

// ===== pdis_serial_rx.sv
// Link-side serial shifter, clocked by the controller's serial clock.
// Assumes enable and data are stable around each rising clock edge and
// that the clock stands still between transfers.
`timescale 1ns/1ns
module pdis_serial_rx
(
   input wire logic serial_clock_pin,
   input wire logic reset_n,
   input wire logic ce_pin,
   input wire logic serial_in_pin,
   input wire logic [15:0] tx_word,
   output logic [31:0] frame_word,
   output logic frame_toggle,
   output logic serial_out
);

   localparam logic [4:0] LAST_BIT = 5'(pdis_pkg::FRAME_BITS - 1);

   logic [31:0] shift_reg; // Incoming bits, newest in bit 0
   logic [4:0] cnt_reg; // Bit position in the frame
   logic [31:0] word_reg; // Last complete frame
   logic tog_reg; // Flips once per complete frame
   logic [15:0] tx_reg; // Outgoing bits
   logic out_reg; // Bit on the output pin
   wire frame_rst_n = reset_n & ce_pin; // Enable low restarts the frame
   wire last_bit = (cnt_reg == LAST_BIT);

   // Bit counter; cleared whenever the controller drops enable
   always_ff @(posedge serial_clock_pin or negedge frame_rst_n)
   begin
      if (!frame_rst_n)
         cnt_reg <= 5'h00;
      else
         cnt_reg <= last_bit ? 5'h00 : cnt_reg + 5'h01;
   end

   // Sample data in on the rising edge
   always_ff @(posedge serial_clock_pin or negedge reset_n)
   begin
      if (!reset_n)
         shift_reg <= 32'h00000000;
      else if (ce_pin)
         shift_reg <= {shift_reg[30:0], serial_in_pin};
   end

   // Whole frame captured; the toggle tells the system side
   always_ff @(posedge serial_clock_pin or negedge reset_n)
   begin
      if (!reset_n)
      begin
         word_reg <= 32'h00000000;
         tog_reg <= 1'b0;
      end
      else if (ce_pin && last_bit)
      begin
         word_reg <= {shift_reg[30:0], serial_in_pin};
         tog_reg <= ~tog_reg;
      end
   end

   // Output shifter; the word is quiet while enable is high
   always_ff @(posedge serial_clock_pin or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tx_reg <= 16'h0000;
         out_reg <= 1'b0;
      end
      else if (ce_pin && cnt_reg == 5'h00)
      begin
         tx_reg <= {tx_word[14:0], 1'b0};
         out_reg <= tx_word[15];
      end
      else
      begin
         tx_reg <= {tx_reg[14:0], 1'b0};
         out_reg <= tx_reg[15];
      end
   end

   assign frame_word = word_reg;
   assign frame_toggle = tog_reg;
   assign serial_out = out_reg;

   a_frame_flip: assert property (@(posedge serial_clock_pin) disable iff (!frame_rst_n)
      last_bit |=> tog_reg != $past(tog_reg))
      else $error("frame toggle missed");
   a_rise_sample: assert property (@(posedge serial_clock_pin) disable iff (!reset_n)
      ce_pin |=> shift_reg[0] == $past(serial_in_pin))
      else $error("data bit not sampled");

endmodule

// ===== pdis_top.sv
// Divider input selector: serial control port, divider and registers.
// Assumes a classic Wishbone master on clk_sys and a serial controller
// whose clock is unrelated to clk_sys.
`timescale 1ns/1ns
module pdis_top
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic serial_clock_pin,
   input wire logic ce_pin,
   input wire logic serial_in_pin,
   output logic serial_out_pin,
   output logic serial_out_oe,
   input wire logic high_band_lo_input,
   input wire logic low_band_lo_input,
   output logic [4:0] dedicated_out_port,
   output logic [4:0] dedicated_out_oe,
   input wire logic [1:0] bidir_port_in,
   output logic [1:0] bidir_port_out,
   output logic [1:0] bidir_port_oe,
   output logic comparator_pulse
);

   // Link side outputs
   logic [31:0] rx_word; // Last frame, stable between frames
   logic rx_toggle; // Flips per frame, link domain
   logic rx_out; // Serial output bit, link domain

   // Crossing stages
   logic [2:0] tog_sync_reg; // Frame toggle sync plus history
   logic [1:0] ce_sync_reg; // Enable level sync
   logic [1:0] io_sync_reg0; // Port pin level sync, first stage
   logic [1:0] io_sync_reg1; // Port pin level sync, second stage

   // Control state
   pdis_pkg::pdis_cfg_t cfg_reg; // Held control data
   pdis_pkg::pdis_cfg_t cfg_next;
   logic frame_seen_reg; // Any frame since reset
   logic run_reg; // Software divider enable
   logic [15:0] tx_word_reg; // Word for the next read transfer
   logic [15:0] tx_word_next;
   logic do_oe_reg;
   logic [4:0] bo_oe_reg;
   logic [1:0] io_oe_reg;
   logic pulse_out_reg;
   logic [31:0] pulse_cnt_reg; // Divider output pulses
   logic [15:0] frame_cnt_reg; // Frames received

   // Bus state
   logic ack_reg;
   logic [31:0] dat_reg;

   // Divider
   logic div_pulse;
   logic div_active;

   // Decoded events and selections
   wire new_frame = tog_sync_reg[1] ^ tog_sync_reg[2];
   wire link_busy = ce_sync_reg[1];
   wire [15:0] cfg_div = cfg_reg.divisor;
   wire cfg_ok = pdis_pkg::pdis_cfg_ok(cfg_reg.band | cfg_reg.swallow, cfg_reg.divisor);
   wire doc_valid = (cfg_reg.doc != pdis_pkg::DOC_OPEN) && (cfg_reg.doc <= pdis_pkg::DOC_PULSE);
   wire bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
   wire bus_wr = bus_req & wb_we_i;
   wire ctrl_wr = bus_wr & (wb_adr_i == pdis_pkg::ADR_CTRL) & wb_sel_i[0];

   // Serial shifter in the serial clock domain
   pdis_serial_rx u_rx
   (
      .serial_clock_pin(serial_clock_pin),
      .reset_n(reset_n),
      .ce_pin(ce_pin),
      .serial_in_pin(serial_in_pin),
      .tx_word(tx_word_reg),
      .frame_word(rx_word),
      .frame_toggle(rx_toggle),
      .serial_out(rx_out)
   );

   // Divider on the selected input
   pdis_divider u_div
   (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .run(run_reg),
      .restart(new_frame),
      .cfg(cfg_reg),
      .high_band_lo_input(high_band_lo_input),
      .low_band_lo_input(low_band_lo_input),
      .pulse(div_pulse),
      .active(div_active)
   );

   // Frame bits map straight onto the held control data
   assign cfg_next = pdis_pkg::pdis_cfg_t'(rx_word[pdis_pkg::CFG_W-1:0]);

   // Output word picked by the content field
   always_comb
   begin
      case (cfg_reg.doc)
         pdis_pkg::DOC_IO: tx_word_next = {io_sync_reg1, 14'h0000};
         pdis_pkg::DOC_DIV: tx_word_next = cfg_div;
         pdis_pkg::DOC_PULSE: tx_word_next = pulse_cnt_reg[15:0];
         default: tx_word_next = 16'h0000;
      endcase
   end

   // Synchronisers; the link toggle and enable are levels here
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tog_sync_reg <= 3'h0;
         ce_sync_reg <= 2'h0;
         io_sync_reg0 <= 2'h0;
         io_sync_reg1 <= 2'h0;
      end
      else
      begin
         tog_sync_reg <= {tog_sync_reg[1:0], rx_toggle};
         ce_sync_reg <= {ce_sync_reg[0], ce_pin};
         io_sync_reg0 <= bidir_port_in;
         io_sync_reg1 <= io_sync_reg0;
      end
   end

   // Take a frame; the word cannot move again for many link cycles,
   // so reading it two system cycles after the toggle is safe
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cfg_reg <= pdis_pkg::pdis_cfg_t'(pdis_pkg::CFG_RST);
         frame_seen_reg <= 1'b0;
         frame_cnt_reg <= 16'h0000;
      end
      else if (new_frame)
      begin
         cfg_reg <= cfg_next;
         frame_seen_reg <= 1'b1;
         frame_cnt_reg <= frame_cnt_reg + 16'h0001;
      end
   end

   // Output word only changes while no transfer runs, so the link
   // side reads a quiet word; costs freshness during a transfer
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         tx_word_reg <= 16'h0000;
      else if (!link_busy)
         tx_word_reg <= tx_word_next;
   end

   // Pin drivers; zero in control data leaves a pin open
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         do_oe_reg <= 1'b0;
         bo_oe_reg <= 5'h00;
         io_oe_reg <= 2'h0;
      end
      else
      begin
         do_oe_reg <= link_busy & doc_valid;
         bo_oe_reg <= cfg_reg.bo;
         io_oe_reg <= cfg_reg.io_dir & cfg_reg.io_dat;
      end
   end

   // Divider output and pulse tally
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pulse_out_reg <= 1'b0;
         pulse_cnt_reg <= 32'h00000000;
      end
      else
      begin
         pulse_out_reg <= div_pulse;
         if (div_pulse)
            pulse_cnt_reg <= pulse_cnt_reg + 32'h00000001;
      end
   end

   // Software enable; the only writable field
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         run_reg <= pdis_pkg::CTRL_RUN_RST;
      else if (ctrl_wr)
         run_reg <= wb_dat_i[0];
   end

   // Read mux; unmapped addresses read zero
   wire [31:0] status_word = {frame_cnt_reg, 8'h00, div_active, cfg_ok,
                              cfg_reg.band, cfg_reg.swallow, cfg_reg.doc, link_busy};
   wire [31:0] rd_data =
      (wb_adr_i == pdis_pkg::ADR_CTRL) ? {31'h00000000, run_reg} :
      (wb_adr_i == pdis_pkg::ADR_STATUS) ? status_word :
      (wb_adr_i == pdis_pkg::ADR_DIVISOR) ? {16'h0000, cfg_div} :
      (wb_adr_i == pdis_pkg::ADR_PULSES) ? pulse_cnt_reg :
      (wb_adr_i == pdis_pkg::ADR_CONFIG) ? {2'h0, cfg_reg} : 32'h00000000;

   // One wait state; ack drops the cycle after it is given
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h00000000;
      end
      else
      begin
         ack_reg <= bus_req;
         dat_reg <= bus_req ? rd_data : 32'h00000000;
      end
   end

   // Outputs
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;
   assign serial_out_pin = rx_out;
   assign serial_out_oe = do_oe_reg;
   assign dedicated_out_port = 5'h00;
   assign dedicated_out_oe = bo_oe_reg;
   assign bidir_port_out = 2'h0;
   assign bidir_port_oe = io_oe_reg;
   assign comparator_pulse = pulse_out_reg;

   // Checks on the system side
   default clocking cb_sys @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   a_bo_reset_open: assert property (!frame_seen_reg |-> dedicated_out_oe == 5'h00)
      else $error("dedicated output driven before config");
   a_io_reset_input: assert property (!frame_seen_reg |-> bidir_port_oe == 2'h0)
      else $error("port pin driven before config");
   a_cfg_from_frame: assert property (new_frame |=> cfg_reg == $past(cfg_next))
      else $error("frame not loaded");
   a_cfg_hold: assert property (!new_frame |=> $stable(cfg_reg))
      else $error("config changed without frame");
   a_do_open_code: assert property ((cfg_reg.doc == pdis_pkg::DOC_OPEN) |=> !serial_out_oe)
      else $error("output driven with open code");
   a_do_div_word: assert property ((!link_busy && cfg_reg.doc == pdis_pkg::DOC_DIV)
      |=> tx_word_reg == $past(cfg_div))
      else $error("divisor word not presented");
   a_reset_defaults: assert property (!frame_seen_reg |-> cfg_reg.doc == pdis_pkg::DOC_OPEN)
      else $error("control state not default");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");

   c_frame_in: cover property (new_frame ##1 frame_seen_reg);
   c_io_read: cover property (link_busy && cfg_reg.doc == pdis_pkg::DOC_IO);
   c_div_pulse: cover property (comparator_pulse && !cfg_reg.band);
   c_ctrl_write: cover property (ctrl_wr);

endmodule

// ===== tb_pll_divider_input_select.sv
// Self-checking bench for the divider input selector: bus, serial
// link, divider paths and reset defaults.
// Assumes the serial controller model pdis_ctrl_model beside it.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_pll_divider_input_select;
   logic clk_sys;
   logic reset_n;
   logic wb_cyc_i;
   logic wb_stb_i;
   logic wb_we_i;
   logic [4:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   wire logic sclk;
   wire logic ce;
   wire logic sdi;
   logic serial_out_pin;
   logic serial_out_oe;
   // Three-state data line with a pull-up: a released pin reads high
   wire logic sdo_line = serial_out_oe ? serial_out_pin : 1'b1;
   logic hi_in;
   logic lo_in;
   logic [4:0] dedicated_out_oe;
   logic [1:0] bidir_port_in;
   logic [1:0] bidir_port_oe;
   logic comparator_pulse;
   int fails = 0;
   int samples_checked = 0;
   int pulse_cnt = 0;
   int cycles = 0;
   logic [31:0] d;
   logic [15:0] rw;

   pdis_top uut (.clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .serial_clock_pin(sclk), .ce_pin(ce), .serial_in_pin(sdi),
      .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe), .high_band_lo_input(hi_in),
      .low_band_lo_input(lo_in), .dedicated_out_port(), .dedicated_out_oe(dedicated_out_oe),
      .bidir_port_in(bidir_port_in), .bidir_port_out(), .bidir_port_oe(bidir_port_oe),
      .comparator_pulse(comparator_pulse));

   pdis_ctrl_model ctl (.sclk(sclk), .ce(ce), .sdi(sdi), .sdo(sdo_line));

   // 50 MHz system clock
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // Pulse tally and hang guard; a whole run needs about 50000 cycles
   always @(posedge clk_sys)
   begin
      cycles++;
      if (comparator_pulse === 1'b1)
         pulse_cnt++;
      if (cycles == 90000)
      begin
         fails++;
         results();
      end
   end

   // Closing report
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Classic single Wishbone cycle; entered just after a rising edge
   task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= wd;
      // Wait for ack however long it takes; only the bench timeout ends this
      do
         @(posedge clk_sys);
      while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_sys);
   endtask

   // One serial transfer, then the gap the link synchroniser needs
   task automatic link(input logic [31:0] fr, input int nbits);
      ctl.xfer(fr, nbits, rw);
      repeat (60) @(posedge clk_sys);
   endtask

   // Rising edges on one oscillator input, 160 ns period
   task automatic osc(input logic hi, input int n);
      repeat (n)
      begin
         repeat (4) @(posedge clk_sys);
         if (hi)
            hi_in <= 1'b1;
         else
            lo_in <= 1'b1;
         repeat (4) @(posedge clk_sys);
         hi_in <= 1'b0;
         lo_in <= 1'b0;
      end
      repeat (10) @(posedge clk_sys);
   endtask

   // Load a frame, feed edges, count comparator pulses
   task automatic run_case(input logic [31:0] fr, input logic hi, input int n, input int exp);
      int p0;
      logic ok_exp;
      // Accepted range follows from the band and mode bits of the frame
      ok_exp = (fr[16] | fr[17]) ? (fr[15:0] >= pdis_pkg::SWAL_MIN) :
         ((fr[15:0] >= pdis_pkg::DIR_MIN) && (fr[15:0] <= pdis_pkg::DIR_MAX));
      link(fr, 32);
      wb(1'b0, pdis_pkg::ADR_CONFIG, 32'h00000000, d);
      `CHK("config", {2'b00, fr[29:0]}, d)
      wb(1'b0, pdis_pkg::ADR_STATUS, 32'h00000000, d);
      `CHK("in range", ok_exp, d[6])
      p0 = pulse_cnt;
      osc(hi, n);
      `CHK("pulses", exp, pulse_cnt - p0)
      $display("divider case done");
   endtask

   // Main sequence
   initial
   begin
      reset_n = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 5'h00;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h00000000;
      hi_in = 1'b0;
      lo_in = 1'b0;
      bidir_port_in = 2'b10;
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      `CHK("bo oe", 5'h00, dedicated_out_oe)
      `CHK("io oe", 2'h0, bidir_port_oe)
      wb(1'b0, pdis_pkg::ADR_CTRL, 32'h00000000, d);
      `CHK("ctrl", 32'h00000001, d)
      wb(1'b1, pdis_pkg::ADR_CONFIG, 32'hFFFFFFFF, d);
      wb(1'b0, pdis_pkg::ADR_CONFIG, 32'h00000000, d);
      `CHK("config", 32'h00000000, d)
      wb(1'b0, 5'h14, 32'h00000000, d);
      `CHK("unmapped", 32'h00000000, d)
      $display("reset test done");
      run_case({11'h000, 3'h0, 1'b0, 1'b1, 16'h0110}, 1'b1, 1088, 2);
      run_case({11'h000, 3'h0, 1'b0, 1'b1, 16'h010F}, 1'b1, 40, 0);
      run_case({11'h000, 3'h0, 1'b1, 1'b0, 16'h0110}, 1'b0, 544, 2);
      run_case({11'h000, 3'h0, 1'b1, 1'b0, 16'h0110}, 1'b1, 544, 0);
      run_case({11'h000, 3'h3, 1'b0, 1'b0, 16'h0004}, 1'b0, 12, 3);
      // Stopped divider ignores edges
      wb(1'b1, pdis_pkg::ADR_CTRL, 32'h00000000, d);
      osc(1'b0, 8);
      `CHK("stopped", 7, pulse_cnt)
      wb(1'b1, pdis_pkg::ADR_CTRL, 32'h00000001, d);
      link(32'h00000000, 17);
      `CHK("out pulses", pulse_cnt[15:0], rw)
      run_case({11'h000, 3'h2, 1'b0, 1'b0, 16'h0FFF}, 1'b0, 4095, 1);
      link(32'h00000000, 17);
      `CHK("out divisor", 16'h0FFF, rw)
      run_case({11'h000, 3'h1, 1'b0, 1'b0, 16'h1000}, 1'b0, 20, 0);
      link(32'h00000000, 17);
      `CHK("out pins", 16'h8000, rw)
      // Port settings, then a second reset in mid-run
      link({2'b00, 2'b01, 2'b11, 5'h15, 3'h0, 1'b0, 1'b0, 16'h0004}, 32);
      `CHK("bo oe", 5'h15, dedicated_out_oe)
      `CHK("io oe", 2'h1, bidir_port_oe)
      reset_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      `CHK("bo oe", 5'h00, dedicated_out_oe)
      `CHK("io oe", 2'h0, bidir_port_oe)
      reset_n <= 1'b1;
      @(posedge clk_sys);
      wb(1'b0, pdis_pkg::ADR_CONFIG, 32'h00000000, d);
      `CHK("config", 32'h00000000, d)
      link(32'h00000000, 17);
      `CHK("out open", 16'hFFFF, rw)
      $display("port and reset test done");
      results();
   end
endmodule
